/* File: hdl/owbr_line_timer.sv */
/*
  Control line synchroniser, edge detector and high/low interval counters.
  Assumes the line is asynchronous to clk; counts saturate on very long intervals.
*/
`timescale 1ns/1ps
`default_nettype none
module owbr_line_timer
(
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          ctrlIn,
    output var  owbr_pkg::owbr_line_t line
);
    import owbr_pkg::*;

    typedef struct packed {
        logic             s1;
        logic             s2;
        logic             s3;
        logic [CNT_W-1:0] low;
        logic [CNT_W-1:0] high;
    } owbr_tmr_t;

    owbr_tmr_t r_q;
    owbr_tmr_t r_d;

    function automatic logic [CNT_W-1:0] satInc(input logic [CNT_W-1:0] v);
        satInc = (&v) ? v : v + 1'b1;
    endfunction : satInc

    // Only s2 and later stages feed logic; s1 is read by s2 alone
    always_comb
    begin
        r_d    = r_q;
        r_d.s1 = ctrlIn;            // R17
        r_d.s2 = r_q.s1;
        r_d.s3 = r_q.s2;
        if (r_q.s3 && !r_q.s2)
        begin
            r_d.low  = {{(CNT_W-1){1'b0}}, 1'b1};
            r_d.high = '0;
        end
        else if (!r_q.s2)
            r_d.low = satInc(r_q.low);     // R17
        else
            r_d.high = satInc(r_q.high);   // R17
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            r_q.s1   <= 1'b1;
            r_q.s2   <= 1'b1;
            r_q.s3   <= 1'b1;
            r_q.low  <= '0;
            r_q.high <= '0;
        end
        else
            r_q <= r_d;
    end

    // Counts shown at a falling edge are the totals of the bit just closed
    assign line.fall    = r_q.s3 & ~r_q.s2;
    assign line.rise    = ~r_q.s3 & r_q.s2;
    assign line.level   = r_q.s2;
    assign line.lowCnt  = r_q.low;
    assign line.highCnt = r_q.high;

endmodule : owbr_line_timer
`default_nettype wire

/* File: hdl/owbr_receiver.sv */
/*
  One-wire brightness command receiver with open-drain acknowledge.
  Assumes an external pull-up on the control line; ctrlOut/ctrlOe drive its pull-down.
*/
`timescale 1ns/1ps
`default_nettype none
module owbr_receiver
#(
    parameter int ACK_HOLD_CYC = owbr_pkg::ACK_HOLD_CYC,
    parameter int VALID_CYC    = owbr_pkg::VALID_CYC
)
(
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic                         ctrlIn,
    output logic                              ctrlOut,
    output logic                              ctrlOe,
    output logic [owbr_pkg::LEVEL_W-1:0]      level,
    output logic                              levelStrobe,
    output logic                              frameError
);
    import owbr_pkg::*;

    typedef struct packed {
        owbr_state_t        state;
        logic [3:0]         bitCnt;
        logic               byteIdx;
        logic [7:0]         shift;
        logic [7:0]         addrByte;
        logic [7:0]         dataByte;
        logic [TMR_W-1:0]   timer;
        logic [LEVEL_W-1:0] level;
        logic               strobe;
        logic               err;
        logic               oe;
    } owbr_rx_t;

    owbr_rx_t   s_q;
    owbr_rx_t   s_d;
    owbr_line_t line;
    logic       bitOk;
    logic       bitVal;
    logic [7:0] nextByte;

    owbr_line_timer u_line
    (
        .clk    (clk),
        .rst    (rst),
        .ctrlIn (ctrlIn),
        .line   (line)
    );

    // Ratio decision; doubling is one bit wider so it cannot wrap
    always_comb
    begin
        bitVal   = ({1'b0, line.highCnt} >= {line.lowCnt, 1'b0});   // R06
        bitOk    = bitVal || ({1'b0, line.lowCnt} >= {line.highCnt, 1'b0});   // R06
        nextByte = {s_q.shift[6:0], bitVal};                          // R01
    end

    // Receive sequence; any malformed interval drops back to idle with an error pulse
    always_comb
    begin
        s_d        = s_q;
        s_d.strobe = 1'b0;
        s_d.err    = 1'b0;
        unique case (s_q.state)
            ST_IDLE:
            begin
                // A falling edge from a high line opens the address byte at once
                if (line.fall)                                        // R04
                begin
                    s_d.state   = ST_BITS;                            // R07
                    s_d.bitCnt  = 4'h0;
                    s_d.byteIdx = 1'b0;                               // R15
                end
            end
            ST_BITS:
            begin
                if (line.fall)                                        // R07
                begin
                    if (!bitOk)
                    begin
                        s_d.err   = 1'b1;                             // R08
                        s_d.state = ST_IDLE;
                    end
                    else
                    begin
                        s_d.shift  = nextByte;                        // R01
                        s_d.bitCnt = s_q.bitCnt + 4'h1;
                        if (s_q.bitCnt == 4'(BYTE_BITS - 1))
                        begin
                            s_d.state = ST_EOB;
                            if (!s_q.byteIdx)
                                s_d.addrByte = nextByte;              // R15
                            else
                            begin
                                s_d.dataByte = nextByte;
                                // Register select must be zero for a level write
                                if (s_q.addrByte == OWN_ADDR && !nextByte[REG_SEL_HI]
                                    && !nextByte[REG_SEL_LO])         // R16
                                begin
                                    s_d.level  = nextByte[LEVEL_BIT_TOP:LEVEL_BIT_BOTTOM];
                                    s_d.strobe = 1'b1;
                                end
                                if (s_q.addrByte == OWN_ADDR && nextByte[ACK_REQUEST_FLAG])
                                begin
                                    s_d.state = ST_VALID;             // R08
                                    s_d.timer = '0;
                                end
                            end
                        end
                    end
                end
            end
            ST_EOB:
            begin
                // Too short a low gap means the host broke framing
                if (line.rise)
                begin
                    if (line.lowCnt < CNT_W'(BYTE_END_CYC))           // R05
                    begin
                        s_d.err   = 1'b1;
                        s_d.state = ST_IDLE;
                    end
                    else
                        s_d.state = s_q.byteIdx ? ST_IDLE : ST_START;
                end
            end
            ST_START:
            begin
                if (line.fall)
                begin
                    if (line.highCnt >= CNT_W'(START_CYC))            // R03
                    begin
                        s_d.state   = ST_BITS;
                        s_d.bitCnt  = 4'h0;
                        s_d.byteIdx = 1'b1;
                    end
                    else
                    begin
                        s_d.err   = 1'b1;                             // R03
                        s_d.state = ST_IDLE;
                    end
                end
            end
            ST_VALID:
            begin
                // Host holds the line low here, so no edge can be mistaken
                s_d.timer = s_q.timer + 1'b1;
                if (s_q.timer == TMR_W'(VALID_CYC - 1))               // R10
                begin
                    s_d.state = ST_ACK;
                    s_d.oe    = 1'b1;                                 // R09
                    s_d.timer = '0;
                end
            end
            ST_ACK:
            begin
                s_d.timer = s_q.timer + 1'b1;
                if (s_q.timer == TMR_W'(ACK_HOLD_CYC - 1))            // R09
                begin
                    s_d.state = ST_IDLE;
                    s_d.oe    = 1'b0;
                end
            end
            default:
                s_d.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_q.state    <= ST_IDLE;
            s_q.bitCnt   <= 4'h0;
            s_q.byteIdx  <= 1'b0;
            s_q.shift    <= 8'h00;
            s_q.addrByte <= 8'h00;
            s_q.dataByte <= 8'h00;
            s_q.timer    <= '0;
            s_q.level    <= LEVEL_RESET;
            s_q.strobe   <= 1'b0;
            s_q.err      <= 1'b0;
            s_q.oe       <= 1'b0;
        end
        else
            s_q <= s_d;
    end

    // Open drain: only ever pulls low, never drives high
    assign ctrlOut     = 1'b0;
    assign ctrlOe      = s_q.oe;
    assign level       = s_q.level;
    assign levelStrobe = s_q.strobe;
    assign frameError  = s_q.err;

    // Helper: length of the current pull-down pulse
    logic [TMR_W-1:0] ackRun_q;
    always_ff @(posedge clk)
    begin
        if (rst || !s_q.oe)
            ackRun_q <= '0;
        else
            ackRun_q <= ackRun_q + 1'b1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_msb_first: assert property ((s_q.state == ST_BITS && line.fall && bitOk)   // R01
        |=> s_q.shift == {$past(s_q.shift[6:0]), $past(bitVal)})
        else $error("bit not shifted in at the low end");
    chk_start_short: assert property ((s_q.state == ST_START && line.fall        // R03
        && line.highCnt < CNT_W'(START_CYC)) |=> frameError && s_q.state == ST_IDLE)
        else $error("short start condition accepted");
    chk_idle_open: assert property ((s_q.state == ST_IDLE && line.fall)          // R04
        |=> s_q.state == ST_BITS && s_q.bitCnt == 4'h0 && !s_q.byteIdx)
        else $error("address byte not opened from idle");
    chk_bad_ratio: assert property ((s_q.state == ST_BITS && line.fall && !bitOk) // R06
        |=> frameError ##1 !frameError)
        else $error("ambiguous bit not flagged");
    chk_ack_cause: assert property ($rose(ctrlOe)                                // R08
        |-> s_q.addrByte == OWN_ADDR && s_q.dataByte[ACK_REQUEST_FLAG])
        else $error("acknowledge without request or address match");
    chk_ack_length: assert property ($fell(ctrlOe)                               // R09
        |-> $past(ackRun_q) == TMR_W'(ACK_HOLD_CYC - 1))
        else $error("acknowledge pulse length wrong");
    chk_ack_delay: assert property ($rose(ctrlOe)                                // R10
        |-> $past(s_q.state) == ST_VALID && $past(s_q.timer) == TMR_W'(VALID_CYC - 1))
        else $error("pull-down before validation delay");
    chk_level_write: assert property (levelStrobe                                // R16
        |-> level == s_q.dataByte[LEVEL_BIT_TOP:LEVEL_BIT_BOTTOM] && !s_q.dataByte[REG_SEL_HI]
            && !s_q.dataByte[REG_SEL_LO] && s_q.addrByte == OWN_ADDR)
        else $error("level not taken from data byte");
    chk_sync_path: assert property (line.fall                                    // R17
        |-> $past(ctrlIn, 3) && !$past(ctrlIn, 2))
        else $error("falling edge not from synchronised line");

    cov_ack_done: cover property ($fell(ctrlOe));
    cov_level_set: cover property (levelStrobe);
    cov_frame_err: cover property (frameError);

endmodule : owbr_receiver
`default_nettype wire

/* File: shared/owbr_pkg.sv */
/*
  Shared constants and types for the one-wire brightness receiver.
  Assumes a 50 MHz system clock; every time below is turned into clock cycles here.
*/
// Functional notes
// R01: Bytes travel and are assembled most significant bit first, least significant last.
// R02: Host sends a start condition before the address byte and the data byte; the host model sends one before the data byte only.
// R03: Start condition is line high at least 2 us; next falling edge opens bit one.
// R04: If the line is already high, the address byte needs no start condition.
// R05: Host holds an end-of-byte condition at least 2 us after every byte.
// R06: One means high at least twice low; zero means low at least twice high.
// R07: A bit spans falling edge to falling edge and is decided at the closing edge.
// R08: Acknowledge only with request flag set, matching address, all 16 bits good.
// R09: Acknowledge pulls the line low through the pull-down for at most 512 us.
// R10: Pull-down turns on only after the validation delay from the final falling edge.
// R11: Host keeps the line low during the validation delay of an acknowledged transfer.
// R12: Host releases the line after the delay and reads low as acknowledge.
// R13: Host starts no new transfer before the acknowledge period ends.
// R14: Only an open-drain host may set the acknowledge-request flag.
// R15: First byte is the device address byte; the device answers only to 72 hex.
// R16: Data byte: request flag bit 7, register select bits 6..5 zero, level bits 4..0.
// R17: Line is synchronised and its high and low times counted on the system clock.
`default_nettype none
package owbr_pkg;

    localparam int CLK_NS      = 20;
    localparam int START_NS    = 2000;
    localparam int BYTE_END_NS = 2000;
    localparam int VALID_NS    = 2000;
    localparam int ACK_HOLD_NS = 512000;
    // Least times round up, the longest time rounds down
    localparam int START_CYC    = (START_NS + CLK_NS - 1) / CLK_NS;
    localparam int BYTE_END_CYC = (BYTE_END_NS + CLK_NS - 1) / CLK_NS;
    localparam int VALID_CYC    = (VALID_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACK_HOLD_CYC = ACK_HOLD_NS / CLK_NS;

    localparam int CNT_W     = 12;
    localparam int TMR_W     = 16;
    localparam int BYTE_BITS = 8;
    localparam int LEVEL_W   = 5;

    localparam logic [7:0] OWN_ADDR = 8'h72;
    localparam int ACK_REQUEST_FLAG = 7;
    localparam int REG_SEL_HI       = 6;
    localparam int REG_SEL_LO       = 5;
    localparam int LEVEL_BIT_TOP    = 4;
    localparam int LEVEL_BIT_BOTTOM = 0;
    localparam logic [LEVEL_W-1:0] LEVEL_RESET = 5'h00;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_BITS  = 3'b001,
        ST_EOB   = 3'b010,
        ST_START = 3'b011,
        ST_VALID = 3'b100,
        ST_ACK   = 3'b101
    } owbr_state_t;

    // Synchronised control line with its interval counts
    typedef struct packed {
        logic             fall;
        logic             rise;
        logic             level;
        logic [CNT_W-1:0] lowCnt;
        logic [CNT_W-1:0] highCnt;
    } owbr_line_t;

endpackage : owbr_pkg
`default_nettype wire

/* File: test/owbr_host.sv */
/*
  Host model: open-drain driver of the control line, with bit and transfer tasks.
  Assumes the bench resolves the wired line and feeds it back on lineIn.
*/
`timescale 1ns/1ps
`default_nettype none
module owbr_host
(
    input  wire logic clk,
    input  wire logic lineIn,
    output var  logic hostLow
);
    import owbr_pkg::*;
    time  fallT   = 0;
    logic ackSeen = 1'b0;
    // Gap after the address byte; a bench may shorten it to provoke a framing error
    int   eosLo   = 120;
    initial hostLow = 1'b0;

    // Hold one level for n cycles; every change lands 1 ns after an edge
    task automatic hold(input logic low, input int n);
        hostLow = low;
        repeat (n) @(posedge clk);
        #1;
    endtask : hold

    // Ratio coding; a bad bit has a ratio that is neither a zero nor a one
    task automatic sendBit(input logic b, input bit bad);
        hold(1'b1, bad ? 30 : (b ? 20 : 60));
        hold(1'b0, bad ? 40 : (b ? 60 : 20));
    endtask : sendBit

    // Bad bit goes last, so its closing edge aborts cleanly into idle
    task automatic sendByte(input logic [7:0] v, input bit bad);
        for (int i = 7; i >= 0; i--)
            sendBit(v[i], bad && i == 0);
    endtask : sendByte

    // Line idles high, so the address byte goes without a start
    task automatic frame(input logic [7:0] a, input logic [7:0] d, input int stHi,
                         input bit bad);
        ackSeen = 1'b0;
        sendByte(a, 1'b0);
        hold(1'b1, eosLo);
        hold(1'b0, stHi);
        sendByte(d, bad);
        fallT = $time;
        // Low well past the validation delay, which also serves as end of byte
        hold(1'b1, 120);
        // This model is open-drain, so it may ask for the acknowledge
        if (d[ACK_REQUEST_FLAG])
        begin
            hold(1'b0, 2);
            ackSeen = (lineIn === 1'b0);
            for (int k = 0; k < 1000 && lineIn !== 1'b1; k++)
                hold(1'b0, 1);
        end
        hold(1'b0, 200);
    endtask : frame
endmodule : owbr_host
`default_nettype wire

/* File: test/tb.sv */
/*
  Bench for the receiver: the host model sends transfers, monitors count pulses.
  Assumes shortened acknowledge and validation counts, set below.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) \
    begin \
        checked++; \
        if ((g) !== (e)) \
        begin \
            err_count++; \
            $display("BAD %0t %s", $time, m); \
        end \
    end
module tb;
    import owbr_pkg::*;
    localparam int ACK_CYC = 200;
    localparam int VAL_CYC = 10;
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    logic               hostLow;
    logic               ctrlOut;
    logic               ctrlOe;
    logic [LEVEL_W-1:0] level;
    logic               levelStrobe;
    logic               frameError;
    wire logic          ctrlLine;
    int                 err_count = 0;
    int                 checked = 0;
    int                 nStb, nErr, ackLen, testNo;
    time                ackT;

    // Wired line: low if the host or the device pull-down pulls it
    assign ctrlLine = ~(hostLow | (ctrlOe & ~ctrlOut));
    always #10 clk = ~clk;

    owbr_host host (.clk(clk), .lineIn(ctrlLine), .hostLow(hostLow));
    owbr_receiver #(.ACK_HOLD_CYC(ACK_CYC), .VALID_CYC(VAL_CYC)) DUT
    (
        .clk(clk), .rst(rst), .ctrlIn(ctrlLine), .ctrlOut(ctrlOut), .ctrlOe(ctrlOe),
        .level(level), .levelStrobe(levelStrobe), .frameError(frameError)
    );

    // Pulses stand one cycle, so they are counted at every edge
    always @(posedge clk)
    begin
        if (levelStrobe === 1'b1) nStb++;
        if (frameError === 1'b1) nErr++;
        if (ctrlOe === 1'b1)
        begin
            if (ackLen == 0) ackT = $time;
            ackLen++;
        end
    end

    task automatic doReset;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        `CHK(level, 5'h00, "level after reset")
        `CHK(ctrlOe, 1'b0, "pull-down after reset")
        `CHK(ctrlOut, 1'b0, "open-drain data not low")
    endtask : doReset

    // One transfer, then every observable outcome against expectation
    task automatic run(input logic [7:0] a, input logic [7:0] d, input int stHi,
                       input bit bad, input int eStb, input int eErr, input logic eAck,
                       input logic [LEVEL_W-1:0] eLvl);
        nStb = 0;
        nErr = 0;
        ackLen = 0;
        host.frame(a, d, stHi, bad);
        testNo++;
        `CHK(nStb, eStb, "strobe count")
        `CHK(nErr, eErr, "error count")
        `CHK(level, eLvl, "level")
        `CHK(host.ackSeen, eAck, "ack read back")
        `CHK(ackLen, eAck ? ACK_CYC : 0, "ack length")
        if (eAck)
            `CHK((ackT - host.fallT) > VAL_CYC * 20 && (ackT - host.fallT) < 400, 1'b1,
                 "ack delay")
        $display("test %0d done", testNo);
    endtask : run

    task automatic conclude;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude

    // Main sequence; a short start goes just before a reset since it leaves the link mid-byte
    initial
    begin
        testNo = 0;
        doReset();
        run(8'h72, 8'h15, 120, 1'b0, 1, 0, 1'b0, 5'h15);
        run(8'h73, 8'h0A, 120, 1'b0, 0, 0, 1'b0, 5'h15);
        run(8'h72, 8'h2A, 120, 1'b0, 0, 0, 1'b0, 5'h15);
        run(8'h72, 8'h8A, 120, 1'b0, 1, 0, 1'b1, 5'h0A);
        run(8'h73, 8'h8C, 120, 1'b0, 0, 0, 1'b0, 5'h0A);
        run(8'h72, 8'h9F, 120, 1'b1, 0, 1, 1'b0, 5'h0A);
        run(8'h72, 8'h00, 50, 1'b0, 0, 1, 1'b0, 5'h0A);
        doReset();
        run(8'h72, 8'h03, 120, 1'b0, 1, 0, 1'b0, 5'h03);
        // Short end-of-byte gap goes last: it leaves the link waiting for a start
        host.eosLo = 60;
        run(8'h72, 8'h01, 120, 1'b0, 0, 1, 1'b0, 5'h03);
        conclude();
    end

    // Watchdog: the sequence needs about 16500 cycles
    initial
    begin
        repeat (60000) @(posedge clk);
        err_count++;
        conclude();
    end
endmodule : tb
`default_nettype wire
